// *** src/acr_ctrl_reg.sv ***
// Purpose: Converter control register, loaded from host write frames.
// Assumes: conv_done and cal_done are one-cycle pulses on sys_clk.
// Notes:   Register is write only; its fields leave as decoded outputs.
`include "acr_map.svh"
`timescale 1ns/1ps
module acr_ctrl_reg (
  input  wire logic        sys_clk,          // System clock, 50 MHz
  input  wire logic        arst_n,           // Asynchronous reset, active low
  input  wire logic        ce,               // Clock enable, freezes sys_clk state when low; link receiver still takes frames
  input  wire logic        link_clk,         // Serial clock from the host
  input  wire logic        frame_n,          // Serial frame marker, active low
  input  wire logic        din,              // Serial data in
  input  wire logic        sleep_n,          // Sleep pin, active low
  input  wire logic        conv_done,        // Conversion finished pulse
  input  wire logic        cal_done,         // Calibration finished pulse
  output logic             conv_start,       // Launch one conversion, pulse
  output logic             cal_start,        // Launch calibration, pulse
  output logic             busy,             // Conversion or calibration pending
  output logic [7:0]       mux_pos,          // Positive input one-hot
  output logic [7:0]       mux_neg,          // Negative input one-hot, zero for ground
  output logic             mux_neg_gnd,      // Negative input tied to ground
  output logic [2:0]       power_cfg,        // {sleep level, power-down select}
  output logic [1:0]       read_target,      // Register shifted out on reads
  output logic             two_wire_mode,    // Data-in pin also drives output
  output logic [4:0]       cal_plan,         // Calibration plan struct
  output logic [1:0]       cal_coef_select,  // Coefficient register for access
  output logic             cal_coef_access,  // Coefficient access enabled
  output logic             frame_seen        // Pulse per completed host frame
);
  // Link side
  logic [15:0] link_word;
  logic        link_toggle;

  acr_link_rx u_link_rx (
    .link_clk (link_clk),
    .arst_n   (arst_n),
    .frame_n  (frame_n),
    .din      (din),
    .word_o   (link_word),
    .toggle_o (link_toggle)
  );

  // Crossings into the system clock
  logic toggle_level;
  logic sleep_level;

  acr_sync u_sync_frame (
    .clk       (sys_clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .reset_val (1'b0),
    .async_in  (link_toggle),
    .level_o   (toggle_level)
  );

  acr_sync u_sync_sleep (
    .clk       (sys_clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .reset_val (1'b0),
    .async_in  (sleep_n),
    .level_o   (sleep_level)
  );

  logic toggle_seen_reg;
  wire  frame_event = (toggle_level != toggle_seen_reg);

  // Decoding of a completed frame; the word is stable for many cycles by now
  wire [1:0]  frame_addr   = link_word[`ACR_ADDR_HI:`ACR_ADDR_LO];
  wire [13:0] frame_data   = link_word[`ACR_DATA_BITS-1:0];
  wire        hit_control  = frame_event && (frame_addr == `ACR_ADDR_CONTROL);
  wire        wr_conv      = frame_data[`ACR_BIT_CONV];
  wire        wr_cal       = frame_data[`ACR_BIT_CALSTART];

  // Stored fields
  acr_pkg::acr_ctrl_t ctrl_reg;
  acr_pkg::acr_ctrl_t ctrl_next;
  logic               conv_pending_reg;
  logic               cal_pending_reg;

  // A start written in the very cycle the running operation completes is accepted
  wire launch_conv = hit_control && wr_conv && (!conv_pending_reg || conv_done);
  wire launch_cal  = hit_control && wr_cal && (!cal_pending_reg || cal_done);

  // Hardware done clears, a new launch in the same cycle wins
  wire conv_pending_next = launch_conv | (conv_pending_reg & ~conv_done);
  wire cal_pending_next  = launch_cal | (cal_pending_reg & ~cal_done);

  always_comb begin
    ctrl_next = ctrl_reg;
    if (hit_control) begin
      // Configuration fields take the frame; start bits are governed below
      ctrl_next.input_config_select = frame_data[`ACR_BIT_CONFIG];
      ctrl_next.channel_code        = frame_data[`ACR_BIT_CH_HI:`ACR_BIT_CH_LO];
      ctrl_next.power_down_sel      = frame_data[`ACR_BIT_PD_HI:`ACR_BIT_PD_LO];
      ctrl_next.read_target         = frame_data[`ACR_BIT_RD_HI:`ACR_BIT_RD_LO];
      ctrl_next.interface_mode      = frame_data[`ACR_BIT_MODE];
      ctrl_next.calibration_kind    = frame_data[`ACR_BIT_CALKIND];
      ctrl_next.calibration_select  = frame_data[`ACR_BIT_CALSEL_HI:`ACR_BIT_CALSEL_LO];
    end else if (frame_event) begin
      // Every frame is also a read cycle: mode returns to three-wire
      ctrl_next.interface_mode = 1'b0;
    end
    ctrl_next.soft_conversion_start = conv_pending_next;
    ctrl_next.calibration_start     = cal_pending_next;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg         <= acr_pkg::acr_ctrl_t'(`ACR_CTRL_RESET);
      conv_pending_reg <= 1'b0;
      cal_pending_reg  <= 1'b0;
      toggle_seen_reg  <= 1'b0;
    end else if (ce) begin
      ctrl_reg         <= ctrl_next;
      conv_pending_reg <= conv_pending_next;
      cal_pending_reg  <= cal_pending_next;
      toggle_seen_reg  <= toggle_level;
    end
  end

  // Channel decode from the next field values
  wire [2:0] ch_next     = ctrl_next.channel_code;
  wire       se_next     = ctrl_next.input_config_select;
  // Code bit 2 set makes the odd input of the pair positive; bits 1..0 pick the pair
  wire [2:0] first_idx   = {ch_next[1:0], 1'b0};
  wire [2:0] pos_idx     = first_idx | {2'h0, ch_next[2]};
  wire [2:0] neg_idx     = first_idx | {2'h0, ~ch_next[2]};
  acr_pkg::acr_mux_t mux_next;

  always_comb begin
    mux_next               = '0;
    mux_next.pos_onehot    = 8'h01 << pos_idx;
    mux_next.neg_onehot    = se_next ? 8'h00 : (8'h01 << neg_idx);
    mux_next.neg_is_ground = se_next;
  end

  // Calibration plan from kind and select
  wire [1:0] cs_next = ctrl_next.calibration_select;
  acr_pkg::acr_cal_plan_t plan_next;

  always_comb begin
    plan_next               = '0;
    plan_next.system_levels = ctrl_next.calibration_kind;
    unique case (cs_next)
      2'h0: begin
        plan_next.do_dac             = 1'b1;
        plan_next.do_gain            = 1'b1;
        plan_next.do_offset          = 1'b1;
        plan_next.gain_before_offset = 1'b1;
      end
      2'h1: begin
        plan_next.do_gain            = 1'b1;
        plan_next.do_offset          = 1'b1;
        plan_next.gain_before_offset = 1'b1;
      end
      2'h2: begin
        plan_next.do_offset = 1'b1;
      end
      2'h3: begin
        plan_next.do_gain = 1'b1;
      end
    endcase
  end

  // Registered outputs
  logic                   conv_start_reg;
  logic                   cal_start_reg;
  logic                   busy_reg;
  acr_pkg::acr_mux_t      mux_reg;
  logic [2:0]             power_cfg_reg;
  logic [1:0]             read_target_reg;
  logic                   two_wire_reg;
  acr_pkg::acr_cal_plan_t plan_reg;
  logic [1:0]             coef_sel_reg;
  logic                   coef_access_reg;
  logic                   frame_seen_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_start_reg  <= 1'b0;
      cal_start_reg   <= 1'b0;
      busy_reg        <= 1'b0;
      mux_reg         <= {8'h01, 8'h02, 1'b0};
      power_cfg_reg   <= 3'h0;
      read_target_reg <= 2'h0;
      two_wire_reg    <= 1'b0;
      plan_reg        <= 5'h0f;
      coef_sel_reg    <= 2'h0;
      coef_access_reg <= 1'b1;
      frame_seen_reg  <= 1'b0;
    end else if (ce) begin
      // Start pulses also serve the system calibration sequencer
      conv_start_reg  <= launch_conv;
      cal_start_reg   <= launch_cal;
      busy_reg        <= conv_pending_next | cal_pending_next;
      mux_reg         <= mux_next;
      power_cfg_reg   <= {sleep_level, ctrl_next.power_down_sel};
      read_target_reg <= ctrl_next.read_target;
      two_wire_reg    <= ctrl_next.interface_mode;
      plan_reg        <= plan_next;
      coef_sel_reg    <= ctrl_next.calibration_select;
      coef_access_reg <= ~cal_pending_next;
      frame_seen_reg  <= frame_event;
    end
  end

  assign conv_start      = conv_start_reg;
  assign cal_start       = cal_start_reg;
  assign busy            = busy_reg;
  assign mux_pos         = mux_reg.pos_onehot;
  assign mux_neg         = mux_reg.neg_onehot;
  assign mux_neg_gnd     = mux_reg.neg_is_ground;
  assign power_cfg       = power_cfg_reg;
  assign read_target     = read_target_reg;
  assign two_wire_mode   = two_wire_reg;
  assign cal_plan        = plan_reg;
  assign cal_coef_select = coef_sel_reg;
  assign cal_coef_access = coef_access_reg;
  assign frame_seen      = frame_seen_reg;
endmodule

// *** src/acr_link_rx.sv ***
// Purpose: Link-side frame receiver on the serial clock.
// Assumes: Host shifts data MSB first, sampled on rising serial clock.
// Notes:   Word stays held until the next complete frame.
`include "acr_map.svh"
`timescale 1ns/1ps
module acr_link_rx (
  input  wire logic        link_clk, // Serial clock from the host
  input  wire logic        arst_n,   // Asynchronous reset, active low
  input  wire logic        frame_n,  // Frame marker, active low
  input  wire logic        din,      // Serial data in
  output logic [15:0]      word_o,   // Last complete frame
  output logic             toggle_o  // Flips once per complete frame
);
  logic [15:0] shift_reg;
  logic [4:0]  count_reg;
  logic [15:0] word_reg;
  logic        toggle_reg;
  wire  [15:0] shift_next = {shift_reg[14:0], din};
  wire         last_bit   = (count_reg == (`ACR_FRAME_BITS - 5'h01));
  wire         taking     = (count_reg != `ACR_FRAME_BITS);

  // Counter is held clear by the frame marker itself, so a stopped clock leaves no stale count
  always_ff @(posedge link_clk or negedge arst_n or posedge frame_n) begin
    if (!arst_n) begin
      count_reg <= 5'h00;
    end else if (frame_n) begin
      count_reg <= 5'h00;
    end else if (taking) begin
      count_reg <= count_reg + 5'h01;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg  <= 16'h0000;
      word_reg   <= 16'h0000;
      toggle_reg <= 1'b0;
    end else if (!frame_n && taking) begin
      shift_reg <= shift_next;
      if (last_bit) begin
        word_reg   <= shift_next;
        toggle_reg <= ~toggle_reg;
      end
    end
  end

  assign word_o   = word_reg;
  assign toggle_o = toggle_reg;
endmodule

// *** src/acr_map.svh ***
// Purpose: Offsets, field positions, reset values and counts of the converter control register.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
//
// What this block does
// - Write-only fourteen-bit control store, never read back
// - Control updates only when both address bits set
// - Sixteen-bit frame, latched after all bits arrive
// - Every control bit clears to zero at reset
// - Bit 13: pseudo-differential or single-ended inputs
// - Bits 12..10 choose channel for next conversion
// - Channel code decodes to input pair or input
// - Default selection: input 1 positive, input 2 negative
// - Bits 9..8 with sleep pin choose power-down
// - Bits 7..6 choose register shifted out on reads
// - Read targets: result, test, calibration, status; persistent
// - Bit 5 selects three-wire or two-wire interface
// - Mode bit returns to zero after each read
// - Bit 4 starts one conversion, clears at end
// - Bit 3 chooses self or system calibration
// - Bit 0 starts chosen calibration, clears at end
// - With bit 0 low, select picks coefficient register
// - Self calibration step order per select code
// - System calibration step order per select code
// - Conversion start also usable in system calibration
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

`define ACR_FRAME_BITS    5'h10
`define ACR_DATA_BITS     14
`define ACR_ADDR_HI       15
`define ACR_ADDR_LO       14
`define ACR_ADDR_CONTROL  2'h3
`define ACR_CTRL_RESET    14'h0000

`define ACR_BIT_CONFIG    13
`define ACR_BIT_CH_HI     12
`define ACR_BIT_CH_LO     10
`define ACR_BIT_PD_HI     9
`define ACR_BIT_PD_LO     8
`define ACR_BIT_RD_HI     7
`define ACR_BIT_RD_LO     6
`define ACR_BIT_MODE      5
`define ACR_BIT_CONV      4
`define ACR_BIT_CALKIND   3
`define ACR_BIT_CALSEL_HI 2
`define ACR_BIT_CALSEL_LO 1
`define ACR_BIT_CALSTART  0

`endif

// *** src/acr_pkg.sv ***
// Purpose: Types shared by the converter control register files.
// Assumes: Nothing beyond the map header.
// Notes:   Field positions live in acr_map.svh.
package acr_pkg;

  typedef enum logic [1:0] {
    ACR_RD_RESULT,
    ACR_RD_TEST,
    ACR_RD_CALIB,
    ACR_RD_STATUS
  } acr_read_target_t;

  typedef struct packed {
    logic       input_config_select;
    logic [2:0] channel_code;
    logic [1:0] power_down_sel;
    logic [1:0] read_target;
    logic       interface_mode;
    logic       soft_conversion_start;
    logic       calibration_kind;
    logic [1:0] calibration_select;
    logic       calibration_start;
  } acr_ctrl_t;

  typedef struct packed {
    logic       system_levels;
    logic       do_dac;
    logic       do_gain;
    logic       do_offset;
    logic       gain_before_offset;
  } acr_cal_plan_t;

  typedef struct packed {
    logic [7:0] pos_onehot;
    logic [7:0] neg_onehot;
    logic       neg_is_ground;
  } acr_mux_t;

endpackage

// *** src/acr_sync.sv ***
// Purpose: Three-stage synchroniser with an agreement filter.
// Assumes: The input comes from another clock or a pin.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ps
module acr_sync (
  input  wire logic clk,      // Destination clock
  input  wire logic arst_n,   // Asynchronous reset, active low
  input  wire logic ce,       // Clock enable
  input  wire logic reset_val,// Unused; the level is held at zero while in reset
  input  wire logic async_in, // Level from the other domain
  output logic      level_o   // Filtered level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  wire  agree = (s2_reg == s3_reg);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
    end else if (ce) begin
      s1_reg    <= async_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      if (agree) begin
        level_reg <= s3_reg;
      end
    end
  end

  assign level_o = level_reg ^ (reset_val & 1'b0);
endmodule

// *** tb/acr_ctrl_reg_monitor.sv ***
// Purpose: Concurrent checks on the control register outputs.
// Assumes: Every watched port belongs to the sys_clk domain.
// Notes:   Bound to acr_ctrl_reg after the module.
`timescale 1ns/1ps
module acr_ctrl_reg_monitor (
  input wire logic       sys_clk,       // System clock
  input wire logic       arst_n,        // Reset, active low
  input wire logic       conv_done,     // Conversion finished
  input wire logic       cal_done,      // Calibration finished
  input wire logic       conv_start,    // Conversion launch
  input wire logic       cal_start,     // Calibration launch
  input wire logic       busy,          // Operation pending
  input wire logic [7:0] mux_pos,       // Positive input
  input wire logic [7:0] mux_neg,       // Negative input
  input wire logic       mux_neg_gnd,   // Negative is ground
  input wire logic [2:0] power_cfg,     // Power setting
  input wire logic [1:0] read_target,   // Read target
  input wire logic       two_wire_mode, // Interface mode
  input wire logic       frame_seen     // Frame pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_launch;
    conv_start || cal_start;
  endsequence
  sequence s_done;
    $past(conv_done) || $past(cal_done);
  endsequence
  property p_frame_pulse;
    frame_seen |=> !frame_seen;
  endproperty
  property p_conv_pulse;
    conv_start |=> !conv_start;
  endproperty
  property p_launch_on_write;
    s_launch |-> frame_seen;
  endproperty
  property p_busy_set;
    s_launch |-> busy;
  endproperty
  property p_busy_clear;
    $fell(busy) |-> s_done;
  endproperty
  property p_mux_pair;
    !mux_neg_gnd |-> mux_neg == {mux_pos[6], mux_pos[7], mux_pos[4], mux_pos[5],
                                 mux_pos[2], mux_pos[3], mux_pos[0], mux_pos[1]};
  endproperty
  property p_mux_gnd;
    mux_neg_gnd |-> mux_neg == 8'h00 && $onehot(mux_pos);
  endproperty
  property p_fields_hold;
    !frame_seen |-> $stable({mux_pos, power_cfg[1:0], read_target});
  endproperty
  property p_mode_hold;
    $changed(two_wire_mode) |-> frame_seen;
  endproperty
  a_frame_pulse: assert property (p_frame_pulse) else $error("frame pulse too long");
  a_conv_pulse: assert property (p_conv_pulse) else $error("conversion launch too long");
  a_launch_on_write: assert property (p_launch_on_write) else $error("launch without write");
  a_busy_set: assert property (p_busy_set) else $error("busy low at launch");
  a_busy_clear: assert property (p_busy_clear) else $error("busy dropped without done");
  a_mux_pair: assert property (p_mux_pair) else $error("pair decode wrong");
  a_mux_gnd: assert property (p_mux_gnd) else $error("single-ended decode wrong");
  a_fields_hold: assert property (p_fields_hold) else $error("field moved without frame");
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved without frame");
endmodule

bind acr_ctrl_reg acr_ctrl_reg_monitor i_mon (.sys_clk, .arst_n, .conv_done, .cal_done, .conv_start,
  .cal_start, .busy, .mux_pos, .mux_neg, .mux_neg_gnd, .power_cfg, .read_target, .two_wire_mode,
  .frame_seen);

// *** tb/acr_host_model.sv ***
// Purpose: Host side of the serial port, sending write frames.
// Assumes: Called from the bench while no other frame runs.
// Notes:   Link clock stands low outside frames.
`timescale 1ns/1ps
module acr_host_model (
  output logic link_clk, // Serial clock
  output logic frame_n,  // Frame marker, active low
  output logic din       // Serial data
);
  initial begin
    link_clk = 1'b0;
    frame_n = 1'b1;
    din = 1'b1;
  end
  // Sends the first n bits of w, MSB first, one per 80 ns link period
  task automatic send(input logic [15:0] w, input int n);
    #7 frame_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      din = w[i];
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
    end
    frame_n = 1'b1;
    din = ~din;
  endtask
endmodule

// *** tb/tb_adc_control_register.sv ***
// Purpose: Self-checking bench for the converter control register.
// Assumes: Done pulses are driven here in place of the converter core.
// Notes:   Expected fields come from a shadow copy of the written word.
`timescale 1ns/1ps
module tb_adc_control_register;
  logic sys_clk, arst_n, ce, sleep_n, conv_done, cal_done;
  logic link_clk, frame_n, din;
  logic conv_start, cal_start, busy, mux_neg_gnd, two_wire_mode, cal_coef_access, frame_seen;
  logic [7:0] mux_pos, mux_neg;
  logic [2:0] power_cfg;
  logic [1:0] read_target, cal_coef_select;
  logic [4:0] cal_plan;
  logic [13:0] ctrl;
  logic pend;
  int miscompares, comparisons;
  int fs_cnt = 0, cs_cnt = 0, cl_cnt = 0;

  acr_ctrl_reg i_dut (.sys_clk, .arst_n, .ce, .link_clk, .frame_n, .din, .sleep_n, .conv_done,
    .cal_done, .conv_start, .cal_start, .busy, .mux_pos, .mux_neg, .mux_neg_gnd, .power_cfg,
    .read_target, .two_wire_mode, .cal_plan, .cal_coef_select, .cal_coef_access, .frame_seen);
  acr_host_model i_host (.link_clk, .frame_n, .din);

  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (frame_seen === 1'b1) fs_cnt++;
    if (conv_start === 1'b1) cs_cnt++;
    if (cal_start === 1'b1) cl_cnt++;
  end

  function automatic logic [7:0] pos_of(input logic [13:0] c);
    return 8'h01 << {c[11:10], c[12]};
  endfunction
  function automatic logic [7:0] neg_of(input logic [13:0] c);
    return c[13] ? 8'h00 : 8'h01 << {c[11:10], ~c[12]};
  endfunction
  function automatic logic [4:0] plan_of(input logic [13:0] c);
    return {c[3], c[2:1] == 2'h0, c[2:1] != 2'h2, c[2:1] != 2'h3, ~c[2]};
  endfunction

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_all;
    chk(16'(mux_pos), 16'(pos_of(ctrl)));
    chk(16'(mux_neg), 16'(neg_of(ctrl)));
    chk(16'(mux_neg_gnd), 16'(ctrl[13]));
    chk(16'(power_cfg[1:0]), 16'(ctrl[9:8]));
    chk(16'(read_target), 16'(ctrl[7:6]));
    chk(16'(two_wire_mode), 16'(ctrl[5]));
    chk(16'(cal_plan), 16'(plan_of(ctrl)));
    chk(16'(cal_coef_select), 16'(ctrl[2:1]));
  endtask

  // One frame, then counts of frame and launch pulses and all fields
  task automatic wr(input logic [15:0] w, input int n, input int nc, input int nl);
    int f0, c0, l0;
    f0 = fs_cnt;
    c0 = cs_cnt;
    l0 = cl_cnt;
    i_host.send(w, n);
    repeat (12) @(posedge sys_clk);
    #1;
    if (n == 16 && w[15:14] == 2'h3) ctrl = w[13:0] & 14'h3fee;
    else if (n == 16) ctrl[5] = 1'b0;
    pend = pend | (nc + nl > 0);
    chk(16'(fs_cnt - f0), 16'(n == 16));
    chk(16'(cs_cnt - c0), 16'(nc));
    chk(16'(cl_cnt - l0), 16'(nl));
    chk(16'(busy), 16'(pend));
    chk(16'(cal_coef_access), 16'(nl == 0));
    chk_all();
  endtask

  task automatic done(input logic cal);
    @(posedge sys_clk);
    if (cal) cal_done <= 1'b1;
    else conv_done <= 1'b1;
    @(posedge sys_clk);
    {cal_done, conv_done} <= 2'h0;
    @(posedge sys_clk);
    #1;
    pend = 1'b0;
    chk(16'(busy), 16'h0);
    chk(16'(cal_coef_access), 16'h1);
  endtask

  task automatic final_report;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #500000;
    miscompares++;
    final_report();
  end

  initial begin
    logic [31:0] r;
    logic [15:0] w;
    int          nf;
    {ce, arst_n, sleep_n, conv_done, cal_done} = 5'b10100;
    {miscompares, comparisons} = '0;
    ctrl = '0;
    pend = 1'b0;
    r = $urandom(12778);
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk_all();
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      wr({2'h3, i[3:0], r[9:0] & 10'h3ee}, 16, 0, 0);
    end
    for (int i = 0; i < 3; i++) begin
      r = $urandom;
      wr({2'h3, r[13:6], 2'h2, r[3:1], 1'b0}, 16, 0, 0);
      wr({i[1:0], r[29:16]}, 16, 0, 0);
    end
    wr(16'hffee, 15, 0, 0);
    r = $urandom;
    wr({2'h3, r[13:5], 1'b1, r[3:1], 1'b0}, 16, 1, 0);
    wr({2'h3, r[13:5], 1'b1, r[3:1], 1'b0}, 16, 0, 0);
    done(1'b0);
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      wr({2'h3, r[13:5], 1'b0, i[2:0], 1'b1}, 16, 0, 1);
      done(1'b1);
    end
    // Reset in mid-run while a conversion is still pending
    r = $urandom;
    wr({2'h3, r[13:5], 1'b1, r[3:1], 1'b0}, 16, 1, 0);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    ctrl = '0;
    pend = 1'b0;
    @(posedge sys_clk);
    #1;
    chk(16'(busy), 16'h0);
    chk_all();
    @(posedge sys_clk);
    sleep_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    chk(16'(power_cfg[2]), 16'h0);
    @(posedge sys_clk);
    sleep_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
    chk(16'(power_cfg[2]), 16'h1);
    // A frame taken while the clock enable is low is applied once it rises
    @(posedge sys_clk);
    ce <= 1'b0;
    r = $urandom;
    w = {2'h3, r[13:5], 1'b0, r[3:1], 1'b0};
    nf = fs_cnt;
    i_host.send(w, 16);
    repeat (12) @(posedge sys_clk);
    #1;
    chk(16'(fs_cnt - nf), 16'h0);
    chk_all();
    @(posedge sys_clk);
    ce <= 1'b1;
    ctrl = w[13:0] & 14'h3fee;
    repeat (12) @(posedge sys_clk);
    #1;
    chk(16'(fs_cnt - nf), 16'h1);
    chk_all();
    final_report();
  end
endmodule
